// *** hw/sfc_core.sv ***
// Purpose: Device-side serial command port of a 2-Mbit serial flash.
// Assumes: Pins are asynchronous to clock and slower than clock / 6.
// Notes: The array sits outside; reads use rd_addr/rd_data, erases a
// pulse, programs a byte stream through a FIFO closed by prog_end.
//
// How it works
// - Input bits are taken on clock rising edges.
// - Output bits change on clock falling edges only.
// - Active only while select is low.
// - Write protect low enforces the status lock.
// - Hold low freezes the transfer state.
// - Read 03h, fast read 0Bh adds dummy.
// - Address bits 23 to 18 are ignored.
// - Erase opcodes D7h, D8h with address; C7h alone.
// - Small sector 4 KiB, sector 64 KiB.
// - Program 02h, address, 1 to 256 bytes.
// - Non-reads other than program act only on whole-byte select rise.
// - B9h powers down; lone ABh wakes up.
// - Opcode 05h returns the status byte.
// - Opcode 01h plus one byte writes status.
// - 9Fh alternates maker and device codes.
// - ABh with address bit 0 picks first code.
// - All bytes move most significant bit first.
// - Clock level at select fall picks mode.
// - Read address increments and wraps to zero.
`timescale 1ns/1ps
module sfc_core #(
   parameter logic [7:0] MFR_CODE = 8'h5A, // Arbitrary value.
   parameter logic [7:0] DEV_CODE = 8'h3C  // Arbitrary value.
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic sck,
   input wire logic si,
   input wire logic cs_n,
   input wire logic wp_n,
   input wire logic hold_n,
   output logic so,
   output logic so_oe,
   output logic [17:0] rd_addr,
   input wire logic [7:0] rd_data,
   input wire logic busy,
   output logic erase_go,
   output logic [1:0] erase_kind,
   output logic [17:0] erase_addr,
   output logic prog_valid,
   input wire logic prog_ready,
   output logic [17:0] prog_addr,
   output logic [7:0] program_byte,
   output logic prog_end,
   output logic prog_ok,
   output logic power_down,
   output logic write_en,
   output logic [1:0] block_prot,
   output logic status_lock_bit,
   output logic spi_mode3
);
   typedef struct packed {
      logic [2:0] s_cs;
      logic [2:0] s_sck;
      logic [1:0] s_si;
      logic [1:0] s_hold;
      logic [1:0] s_wp;
      sfc_pkg::sfc_phase_t phase;
      sfc_pkg::sfc_src_t src;
      logic mode3;
      logic [2:0] bitcnt;
      logic [2:0] obit;
      logic [8:0] bytecnt;
      logic [7:0] op;
      logic [7:0] sh;
      logic [7:0] wbyte;
      logic [17:0] addr;
      logic [7:0] obuf;
      logic so;
      logic oe;
      logic id_sel;
      logic wen;
      logic [1:0] bp;
      logic lock;
      logic pdown;
      logic fail;
      logic erase_go;
      logic [1:0] erase_kind;
      logic prog_end;
      logic prog_ok;
   } sfc_core_st_t;

   sfc_core_st_t r_reg;
   sfc_core_st_t r_next;
   logic rise;
   logic fall;
   logic cs_fall;
   logic cs_rise;
   logic byte_done;
   logic [7:0] byte_in;
   logic [7:0] stat_byte;
   logic lock_on;
   logic push_v;

   sfc_stream_if #(.W(sfc_pkg::FIFO_W)) push_if ();
   sfc_stream_if #(.W(sfc_pkg::FIFO_W)) drain_if ();

   ////////////////////////////////////////////////////////////////////////
   // Edges come from the second and third sync stages only; hold low
   // hides every clock edge so the transfer simply pauses.
   assign rise = r_reg.s_sck[1] & ~r_reg.s_sck[2] & ~r_reg.s_cs[1]
                 & r_reg.s_hold[1];
   assign fall = ~r_reg.s_sck[1] & r_reg.s_sck[2] & ~r_reg.s_cs[1]
                 & r_reg.s_hold[1];
   assign cs_fall = r_reg.s_cs[2] & ~r_reg.s_cs[1];
   assign cs_rise = ~r_reg.s_cs[2] & r_reg.s_cs[1];
   assign byte_in = {r_reg.sh[6:0], r_reg.s_si[1]};
   assign byte_done = rise && (r_reg.bitcnt == 3'h7);
   assign stat_byte = {r_reg.lock, 3'h0, r_reg.bp, r_reg.wen, busy};
   assign lock_on = r_reg.lock & ~r_reg.s_wp[1];
   assign push_v = byte_done && (r_reg.phase == sfc_pkg::PH_PROG);

   // Program bytes travel with their address; a full FIFO drops the
   // byte and fails the whole command rather than stalling the host.
   assign push_if.valid = push_v;
   assign push_if.data = {r_reg.addr, byte_in};
   assign drain_if.ready = prog_ready;
   assign prog_valid = drain_if.valid;
   assign {prog_addr, program_byte} = drain_if.data;

   sfc_fifo #(.W(sfc_pkg::FIFO_W), .D(sfc_pkg::FIFO_DEPTH)) u_fifo (
      .clock(clock),
      .rst_n(rst_n),
      .in_s(push_if),
      .out_s(drain_if)
   );

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic for the whole port.
   always_comb begin
      logic [7:0] ob;
      ob = 8'h00;
      r_next = r_reg;
      r_next.s_cs = {r_reg.s_cs[1:0], cs_n};
      r_next.s_sck = {r_reg.s_sck[1:0], sck};
      r_next.s_si = {r_reg.s_si[0], si};
      r_next.s_hold = {r_reg.s_hold[0], hold_n};
      r_next.s_wp = {r_reg.s_wp[0], wp_n};
      r_next.erase_go = 1'b0;
      r_next.prog_end = 1'b0;
      if (cs_fall) begin
         // Selection starts a fresh command in the mode the clock shows.
         r_next.phase = sfc_pkg::PH_CMD;
         r_next.mode3 = r_reg.s_sck[1];
         r_next.bitcnt = 3'h0;
         r_next.obit = 3'h0;
         r_next.bytecnt = 9'h000;
         r_next.oe = 1'b0;
         r_next.fail = 1'b0;
      end else if (cs_rise) begin
         // Deselect: output released, program closed; all but reads and program act only here.
         r_next.phase = sfc_pkg::PH_IDLE;
         r_next.oe = 1'b0;
         if (r_reg.phase == sfc_pkg::PH_PROG) begin
            r_next.prog_end = 1'b1;
            r_next.prog_ok = !r_reg.fail && r_reg.bitcnt == 3'h0
                             && r_reg.bytecnt >= sfc_pkg::N_PROG_MIN;
            r_next.wen = 1'b0;
         end else if (r_reg.bitcnt == 3'h0) begin
            if (r_reg.phase == sfc_pkg::PH_DONE) begin
               case (r_reg.op)
                  sfc_pkg::OP_WREN: begin
                     if (r_reg.bytecnt == sfc_pkg::N_SINGLE) begin
                        r_next.wen = 1'b1;
                     end
                  end
                  sfc_pkg::OP_WRDI: begin
                     if (r_reg.bytecnt == sfc_pkg::N_SINGLE) begin
                        r_next.wen = 1'b0;
                     end
                  end
                  sfc_pkg::OP_PDN: begin
                     if (r_reg.bytecnt == sfc_pkg::N_SINGLE) begin
                        r_next.pdown = 1'b1;
                     end
                  end
                  sfc_pkg::OP_CE: begin
                     if (r_reg.bytecnt == sfc_pkg::N_SINGLE && r_reg.wen
                         && !busy) begin
                        r_next.erase_go = 1'b1;
                        r_next.erase_kind = sfc_pkg::ER_CHIP;
                        r_next.wen = 1'b0;
                     end
                  end
                  sfc_pkg::OP_SSE, sfc_pkg::OP_SE: begin
                     if (r_reg.bytecnt == sfc_pkg::N_ERASE && r_reg.wen
                         && !busy) begin
                        r_next.erase_go = 1'b1;
                        r_next.wen = 1'b0;
                        if (r_reg.op == sfc_pkg::OP_SSE) begin
                           r_next.erase_kind = sfc_pkg::ER_SMALL;
                           r_next.addr = r_reg.addr
                              & ~18'(sfc_pkg::SMALL_SECT_BYTES - 1);
                        end else begin
                           r_next.erase_kind = sfc_pkg::ER_SECT;
                           r_next.addr = r_reg.addr
                              & ~18'(sfc_pkg::SECT_BYTES - 1);
                        end
                     end
                  end
                  sfc_pkg::OP_WRSR: begin
                     if (r_reg.bytecnt == sfc_pkg::N_WRSR && r_reg.wen
                         && !lock_on) begin
                        r_next.lock = r_reg.wbyte[sfc_pkg::SR_LOCK];
                        r_next.bp = r_reg.wbyte[sfc_pkg::SR_BP +: 2];
                        r_next.wen = 1'b0;
                     end
                  end
                  default: begin
                  end
               endcase
            end else if (r_reg.phase == sfc_pkg::PH_ADDR
                         && r_reg.op == sfc_pkg::OP_ID2
                         && r_reg.bytecnt == sfc_pkg::N_SINGLE) begin
               r_next.pdown = 1'b0;
            end
         end
      end else begin
         if (rise && r_reg.phase != sfc_pkg::PH_IDLE) begin
            r_next.sh = byte_in;
            r_next.bitcnt = r_reg.bitcnt + 1'b1;
         end
         if (byte_done && r_reg.bytecnt != 9'h1FF) begin
            r_next.bytecnt = r_reg.bytecnt + 1'b1;
         end
         if (byte_done) begin
            unique case (r_reg.phase)
               sfc_pkg::PH_CMD: begin
                  r_next.op = byte_in;
                  if (r_reg.pdown && byte_in != sfc_pkg::OP_ID2) begin
                     r_next.phase = sfc_pkg::PH_IGN;
                  end else begin
                     case (byte_in)
                        sfc_pkg::OP_READ, sfc_pkg::OP_FREAD,
                        sfc_pkg::OP_SSE, sfc_pkg::OP_SE,
                        sfc_pkg::OP_ID2: begin
                           r_next.phase = sfc_pkg::PH_ADDR;
                        end
                        sfc_pkg::OP_PP: begin
                           r_next.phase = (r_reg.wen && !busy)
                              ? sfc_pkg::PH_ADDR : sfc_pkg::PH_IGN;
                        end
                        sfc_pkg::OP_RDSR: begin
                           r_next.phase = sfc_pkg::PH_OUT;
                           r_next.src = sfc_pkg::SRC_STAT;
                        end
                        sfc_pkg::OP_ID1: begin
                           r_next.phase = sfc_pkg::PH_OUT;
                           r_next.src = sfc_pkg::SRC_ID;
                           r_next.id_sel = 1'b0;
                        end
                        sfc_pkg::OP_WRSR: begin
                           r_next.phase = sfc_pkg::PH_DATA;
                        end
                        sfc_pkg::OP_WREN, sfc_pkg::OP_WRDI,
                        sfc_pkg::OP_PDN, sfc_pkg::OP_CE: begin
                           r_next.phase = sfc_pkg::PH_DONE;
                        end
                        default: begin
                           r_next.phase = sfc_pkg::PH_IGN;
                        end
                     endcase
                  end
               end
               sfc_pkg::PH_ADDR: begin
                  // Only the low 18 of 24 shifted bits are kept.
                  r_next.addr = {r_reg.addr[9:0], byte_in};
                  if (r_reg.bytecnt == sfc_pkg::N_ADDR_LAST) begin
                     case (r_reg.op)
                        sfc_pkg::OP_READ: begin
                           r_next.phase = sfc_pkg::PH_OUT;
                           r_next.src = sfc_pkg::SRC_READ;
                        end
                        sfc_pkg::OP_FREAD: begin
                           r_next.phase = sfc_pkg::PH_DUMMY;
                        end
                        sfc_pkg::OP_ID2: begin
                           r_next.phase = sfc_pkg::PH_OUT;
                           r_next.src = sfc_pkg::SRC_ID;
                           r_next.id_sel = byte_in[0];
                        end
                        sfc_pkg::OP_PP: begin
                           r_next.phase = sfc_pkg::PH_PROG;
                        end
                        default: begin
                           r_next.phase = sfc_pkg::PH_DONE;
                        end
                     endcase
                  end
               end
               sfc_pkg::PH_DUMMY: begin
                  r_next.phase = sfc_pkg::PH_OUT;
                  r_next.src = sfc_pkg::SRC_READ;
               end
               sfc_pkg::PH_PROG: begin
                  // Bytes past the page end wrap inside the page.
                  r_next.addr[7:0] = r_reg.addr[7:0] + 1'b1;
                  if (!push_if.ready) begin
                     r_next.fail = 1'b1;
                  end
               end
               sfc_pkg::PH_DATA: begin
                  r_next.wbyte = byte_in;
                  r_next.phase = sfc_pkg::PH_DONE;
               end
               sfc_pkg::PH_IDLE, sfc_pkg::PH_OUT, sfc_pkg::PH_DONE,
               sfc_pkg::PH_IGN: begin
               end
            endcase
         end
         if (fall && r_reg.phase == sfc_pkg::PH_OUT) begin
            // A new byte is fetched at each byte boundary.
            if (r_reg.obit == 3'h0) begin
               unique case (r_reg.src)
                  sfc_pkg::SRC_READ: ob = rd_data;
                  sfc_pkg::SRC_STAT: ob = stat_byte;
                  sfc_pkg::SRC_ID: ob = r_reg.id_sel ? DEV_CODE : MFR_CODE;
               endcase
               r_next.so = ob[7];
               r_next.obuf = {ob[6:0], 1'b0};
               r_next.oe = 1'b1;
               if (r_reg.src == sfc_pkg::SRC_READ) begin
                  r_next.addr = r_reg.addr + 1'b1;
               end
               if (r_reg.src == sfc_pkg::SRC_ID) begin
                  r_next.id_sel = ~r_reg.id_sel;
               end
            end else begin
               r_next.so = r_reg.obuf[7];
               r_next.obuf = {r_reg.obuf[6:0], 1'b0};
            end
            r_next.obit = r_reg.obit + 1'b1;
         end
      end
   end

   // State register; select, hold and protect syncs idle high after reset.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         r_reg <= '0;
         r_reg.s_cs <= 3'h7;
         r_reg.s_hold <= 2'h3;
         r_reg.s_wp <= 2'h3;
         r_reg.bp <= sfc_pkg::BP_RST;
         r_reg.lock <= sfc_pkg::LOCK_RST;
      end else begin
         r_reg <= r_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs; the driver is released while hold is low.
   assign so = r_reg.so;
   assign so_oe = r_reg.oe & r_reg.s_hold[1];
   assign rd_addr = r_reg.addr;
   assign erase_addr = r_reg.addr;
   assign erase_go = r_reg.erase_go;
   assign erase_kind = r_reg.erase_kind;
   assign prog_end = r_reg.prog_end;
   assign prog_ok = r_reg.prog_ok;
   assign power_down = r_reg.pdown;
   assign write_en = r_reg.wen;
   assign block_prot = r_reg.bp;
   assign status_lock_bit = r_reg.lock;
   assign spi_mode3 = r_reg.mode3;

   ////////////////////////////////////////////////////////////////////////
   // Checks on the port's own behaviour.
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_sample_rise: assert property (rise |=> r_reg.sh[0] == $past(r_reg.s_si[1]))
      else $error("input bit not taken on rising clock");
   a_out_on_fall: assert property ($changed(so) |-> $past(fall))
      else $error("output changed without a falling clock");
   a_desel_quiet: assert property (r_reg.s_cs[2] |-> !so_oe)
      else $error("output driven while deselected");
   a_lock_guard: assert property (lock_on |=> r_reg.lock && $stable(r_reg.bp))
      else $error("locked status changed");
   a_hold_freeze: assert property (!r_reg.s_hold[1] && !cs_fall && !cs_rise
      |=> $stable(r_reg.bitcnt) && $stable(r_reg.so))
      else $error("transfer moved during hold");
   a_pd_block: assert property (byte_done && r_reg.phase == sfc_pkg::PH_CMD
      && r_reg.pdown && byte_in != sfc_pkg::OP_ID2
      |=> r_reg.phase == sfc_pkg::PH_IGN)
      else $error("command accepted in power down");
   a_id_toggle: assert property (fall && r_reg.phase == sfc_pkg::PH_OUT
      && r_reg.obit == 3'h0 && r_reg.src == sfc_pkg::SRC_ID
      |=> r_reg.id_sel != $past(r_reg.id_sel))
      else $error("identity codes did not alternate");
   a_addr_wrap: assert property (fall && r_reg.phase == sfc_pkg::PH_OUT
      && r_reg.obit == 3'h0 && r_reg.src == sfc_pkg::SRC_READ
      && r_reg.addr == 18'h3_FFFF |=> r_reg.addr == 18'h0_0000)
      else $error("read address did not wrap");
   a_mode_pick: assert property (cs_fall |=> r_reg.mode3 == $past(r_reg.s_sck[1]))
      else $error("mode not taken from clock level");
   a_ign_stays: assert property (r_reg.phase == sfc_pkg::PH_IGN && !cs_rise
      |=> r_reg.phase == sfc_pkg::PH_IGN && !so_oe)
      else $error("ignored command woke up");

   c_read: cover property (r_reg.phase == sfc_pkg::PH_OUT
      && r_reg.src == sfc_pkg::SRC_READ && so_oe);
   c_prog: cover property (prog_end && prog_ok);
   c_erase: cover property (erase_go);
   c_wrsr: cover property (cs_rise && r_reg.op == sfc_pkg::OP_WRSR);
endmodule

// *** hw/sfc_pkg.sv ***
// Purpose: Shared constants and types of the serial flash command port.
// Assumes: 18-bit byte address inside a 2-Mbit array.
// Notes: Opcodes, status layout, erase sizes and reset values live here.
package sfc_pkg;
   localparam int ADDR_W = 18;
   localparam int PAGE_BYTES = 256;
   localparam int SMALL_SECT_BYTES = 4096;
   localparam int SECT_BYTES = 65536;
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_W = ADDR_W + 8;

   ////////////////////////////////////////////////////////////////////////
   // Command opcodes.
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_FREAD = 8'h0B;
   localparam logic [7:0] OP_SSE = 8'hD7;
   localparam logic [7:0] OP_SE = 8'hD8;
   localparam logic [7:0] OP_CE = 8'hC7;
   localparam logic [7:0] OP_PP = 8'h02;
   localparam logic [7:0] OP_WREN = 8'h06;
   localparam logic [7:0] OP_WRDI = 8'h04;
   localparam logic [7:0] OP_PDN = 8'hB9;
   localparam logic [7:0] OP_RDSR = 8'h05;
   localparam logic [7:0] OP_WRSR = 8'h01;
   localparam logic [7:0] OP_ID1 = 8'h9F;
   localparam logic [7:0] OP_ID2 = 8'hAB;

   ////////////////////////////////////////////////////////////////////////
   // Byte counts that make a command complete, opcode included; N_ADDR_LAST is the count before the last address byte.
   localparam logic [8:0] N_SINGLE = 9'h001;
   localparam logic [8:0] N_WRSR = 9'h002;
   localparam logic [8:0] N_ADDR_LAST = 9'h003;
   localparam logic [8:0] N_ERASE = 9'h004;
   localparam logic [8:0] N_PROG_MIN = 9'h005;

   // Status byte positions and reset values of the writable bits.
   localparam int SR_LOCK = 7;
   localparam int SR_BP = 2;
   localparam int SR_WEN = 1;
   localparam logic [1:0] BP_RST = 2'h0;
   localparam logic LOCK_RST = 1'b0;

   // Erase kinds reported with the erase pulse.
   localparam logic [1:0] ER_SMALL = 2'h0;
   localparam logic [1:0] ER_SECT = 2'h1;
   localparam logic [1:0] ER_CHIP = 2'h2;

   typedef enum logic [3:0] {
      PH_IDLE, PH_CMD, PH_ADDR, PH_DUMMY, PH_OUT,
      PH_PROG, PH_DATA, PH_DONE, PH_IGN
   } sfc_phase_t;

   typedef enum logic [1:0] {
      SRC_READ, SRC_STAT, SRC_ID
   } sfc_src_t;
endpackage

// *** hw/sfc_stream_if.sv ***
// Purpose: Valid/ready word stream between the command port and its FIFO.
// Assumes: Both ends on the same clock.
// Notes: The sender drives valid and data, the receiver drives ready.
`timescale 1ns/1ps
interface sfc_stream_if #(parameter int W = 26) ();
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// *** hw/sfc_fifo.sv ***
// Purpose: Synchronous FIFO for program bytes with their addresses.
// Assumes: One clock; D of at least two.
// Notes: Full and empty come straight from the held count.
`timescale 1ns/1ps
module sfc_fifo #(
   parameter int W = 26,
   parameter int D = 16
) (
   input wire logic clock,
   input wire logic rst_n,
   sfc_stream_if.snk in_s,
   sfc_stream_if.src out_s
);
   localparam int AW = $clog2(D);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } sfc_fifo_st_t;

   sfc_fifo_st_t f_reg;
   sfc_fifo_st_t f_next;
   logic push;
   logic pop;

   ////////////////////////////////////////////////////////////////////////
   // Handshakes; data is read from the stored words.
   assign in_s.ready = (f_reg.cnt != (AW + 1)'(D));
   assign out_s.valid = (f_reg.cnt != '0);
   assign out_s.data = f_reg.mem[f_reg.rp];
   assign push = in_s.valid & in_s.ready;
   assign pop = out_s.valid & out_s.ready;

   // Pointers wrap by compare so that D need not be a power of two.
   always_comb begin
      f_next = f_reg;
      if (push) begin
         f_next.mem[f_reg.wp] = in_s.data;
         f_next.wp = (f_reg.wp == AW'(D - 1)) ? '0 : f_reg.wp + 1'b1;
      end
      if (pop) begin
         f_next.rp = (f_reg.rp == AW'(D - 1)) ? '0 : f_reg.rp + 1'b1;
      end
      if (push && !pop) begin
         f_next.cnt = f_reg.cnt + 1'b1;
      end else if (pop && !push) begin
         f_next.cnt = f_reg.cnt - 1'b1;
      end
   end

   // State register.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         f_reg <= '0;
      end else begin
         f_reg <= f_next;
      end
   end
endmodule

// *** bench/sfc_host.sv ***
// Purpose: SPI host model that drives the serial port of the flash.
// Assumes: Mode 0 framing with eight clocks to each serial bit.
// Notes: A bit taken while the output is released reads as unknown.
`timescale 1ns/1ps
module sfc_host (
   input wire logic clock,
   input wire logic so,
   input wire logic so_oe,
   output logic sck,
   output logic si,
   output logic cs_n
);
   initial begin
      sck = 1'b0;
      si = 1'b0;
      cs_n = 1'b1;
   end
   ////////////////////////////////////////////////////////////
   // The sck level at the select fall picks the mode, then it idles low.
   task automatic sel(input logic m);
      sck <= m;
      repeat (4) @(posedge clock);
      cs_n <= 1'b0;
      repeat (4) @(posedge clock);
      sck <= 1'b0;
   endtask
   // One whole byte; the output is taken mid-high so it has settled.
   task automatic xfer(input logic [7:0] d, output logic [7:0] q);
      for (int i = 7; i >= 0; i--) begin
         si <= d[i];
         repeat (4) @(posedge clock);
         sck <= 1'b1;
         repeat (2) @(posedge clock);
         q[i] = so_oe ? so : 1'bx;
         repeat (2) @(posedge clock);
         sck <= 1'b0;
      end
   endtask
   // Select rises only after whole bytes.
   // The same holds for status commands.
   task automatic desel();
      repeat (4) @(posedge clock);
      cs_n <= 1'b1;
      repeat (8) @(posedge clock);
   endtask
endmodule

// *** bench/sfc_core_bench.sv ***
// Purpose: Self-checking bench of the serial flash command port.
// Assumes: The host model runs mode 0 at 400 ns a bit.
// Notes: Array data is a sum of address fields; pulses are counted.
`timescale 1ns/1ps
`define CHK(a, b) begin \
   checks_done++; \
   if ((a) !== (b)) begin \
      n_errors++; \
      $display("unexpected at %0t: %h %h", $time, a, b); \
   end \
end
module sfc_core_bench;
   localparam logic [7:0] MFR = 8'hA6; // Arbitrary value.
   localparam logic [7:0] DEV = 8'h19; // Arbitrary value.
   logic clock, rst_n, wp_n, hold_n, prog_ready, erase_go, prog_valid;
   logic so, so_oe, sck, si, cs_n, prog_end, prog_ok, power_down;
   logic write_en, status_lock_bit, spi_mode3, busy;
   logic [1:0] erase_kind, block_prot, ek;
   logic [7:0] rd_data, program_byte;
   logic [17:0] rd_addr, erase_addr, prog_addr, ea;
   logic [25:0] pw;
   logic [7:0] rx [32];
   int n_errors, checks_done, n_er, n_pw, n_pe;
   sfc_host h (.clock(clock), .so(so), .so_oe(so_oe), .sck(sck), .si(si),
      .cs_n(cs_n));
   sfc_core #(.MFR_CODE(MFR), .DEV_CODE(DEV)) u_dut (.clock(clock),
      .rst_n(rst_n), .sck(sck), .si(si), .cs_n(cs_n), .wp_n(wp_n),
      .hold_n(hold_n), .so(so), .so_oe(so_oe), .rd_addr(rd_addr),
      .rd_data(rd_data), .busy(busy), .erase_go(erase_go),
      .erase_kind(erase_kind), .erase_addr(erase_addr),
      .prog_valid(prog_valid), .prog_ready(prog_ready),
      .prog_addr(prog_addr), .program_byte(program_byte),
      .prog_end(prog_end), .prog_ok(prog_ok), .power_down(power_down),
      .write_en(write_en), .block_prot(block_prot),
      .status_lock_bit(status_lock_bit), .spi_mode3(spi_mode3));
   function automatic logic [7:0] fdat(input logic [17:0] a);
      return a[7:0] + a[17:10];
   endfunction
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   ////////////////////////////////////////////////////////////
   // Array model, erase log and FIFO consumer log.
   always @(posedge clock) begin
      rd_data <= fdat(rd_addr);
      if (erase_go) begin
         n_er <= n_er + 1;
         {ek, ea} <= {erase_kind, erase_addr};
      end
      if (prog_valid && prog_ready) begin
         n_pw <= n_pw + 1;
         pw <= {prog_addr, program_byte};
      end
      if (prog_end) begin
         n_pe <= n_pe + 1;
      end
   end
   // Sends the bytes, then nr filler bytes whose answers land in rx.
   task automatic frame(input logic [7:0] tx [$], input int nr);
      h.sel(1'b0);
      for (int k = 0; k < tx.size() + nr; k++)
         h.xfer(k < tx.size() ? tx[k] : 8'h00, rx[k]);
      h.desel();
   endtask
   task automatic erase(input logic [7:0] tx [$], input logic [1:0] k,
      input logic [17:0] a);
      int n;
      n = n_er;
      frame('{8'h06}, 0);
      frame(tx, 0);
      `CHK({n_er - n, ek}, {32'd1, k})
      if (k != sfc_pkg::ER_CHIP)
         `CHK(ea, a)
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Main sequence; a refused command must leave state untouched.
   initial begin
      int n;
      {rst_n, wp_n, hold_n, prog_ready, rd_data} = {4'h7, 8'h00};
      busy = 1'b0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      frame('{8'h05}, 1);
      `CHK(rx[1], 8'h00)
      `CHK(so_oe, 1'b0)
      frame('{8'h06}, 0);
      frame('{8'h05}, 1);
      `CHK(rx[1], 8'h02)
      frame('{8'h01, 8'h8C}, 0);
      `CHK({status_lock_bit, block_prot, write_en}, 4'hE)
      wp_n <= 1'b0;
      frame('{8'h06}, 0);
      frame('{8'h01, 8'h00}, 0);
      `CHK(block_prot, 2'h3)
      wp_n <= 1'b1;
      frame('{8'h01, 8'h00}, 0);
      `CHK({status_lock_bit, block_prot}, 3'h0)
      hold_n <= 1'b0;
      frame('{8'h06}, 0);
      hold_n <= 1'b1;
      `CHK(write_en, 1'b0)
      $display("test status done");
      frame('{8'h03, 8'hFF, 8'hFF, 8'hFF}, 2);
      `CHK({rx[4], rx[5]}, {fdat(18'h3FFFF), fdat(18'h0)})
      frame('{8'h0B, 8'h01, 8'h23, 8'h45, 8'h00}, 1);
      `CHK(rx[5], fdat(18'h12345))
      frame('{8'h9F}, 3);
      `CHK({rx[1], rx[2], rx[3]}, {MFR, DEV, MFR})
      frame('{8'hAB, 8'h00, 8'h00, 8'hFF}, 2);
      `CHK({rx[4], rx[5]}, {DEV, MFR})
      frame('{8'hB9}, 0);
      `CHK(power_down, 1'b1)
      frame('{8'hAB}, 0);
      `CHK(power_down, 1'b0)
      $display("test reads done");
      erase('{8'hD7, 8'h03, 8'h56, 8'h78}, sfc_pkg::ER_SMALL, 18'h35000);
      erase('{8'hD8, 8'h03, 8'h56, 8'h78}, sfc_pkg::ER_SECT, 18'h30000);
      erase('{8'hC7}, sfc_pkg::ER_CHIP, 18'h0);
      frame('{8'h06}, 0);
      frame('{8'hD8, 8'h03, 8'h56}, 0);
      `CHK(n_er, 3)
      // A busy array refuses the erase, and status shows busy and wen.
      busy <= 1'b1;
      frame('{8'hC7}, 0);
      frame('{8'h05}, 1);
      busy <= 1'b0;
      `CHK({n_er, rx[1]}, {32'd3, 8'h03})
      frame('{8'h02, 8'h00, 8'h01, 8'hFE, 8'hA1, 8'hB2, 8'hC3}, 0);
      `CHK({prog_ok, pw}, {1'b1, 18'h00100, 8'hC3})
      // The consumer stalls so the FIFO fills and drops the overflow.
      prog_ready <= 1'b0;
      n = n_pw;
      frame('{8'h06}, 0);
      frame('{8'h02, 8'h00, 8'h00, 8'h00}, 18);
      `CHK(prog_ok, 1'b0)
      prog_ready <= 1'b1;
      for (int i = 0; i < 100 && prog_valid !== 1'b0; i++)
         @(posedge clock);
      `CHK(prog_valid, 1'b0)
      `CHK(n_pw - n, sfc_pkg::FIFO_DEPTH)
      `CHK(n_pe, 2)
      $display("test erase and program done");
      h.sel(1'b0);
      h.xfer(8'h77, rx[0]);
      h.xfer(8'h00, rx[1]);
      `CHK(so_oe, 1'b0)
      h.desel();
      h.sel(1'b1);
      h.desel();
      `CHK(spi_mode3, 1'b1)
      h.sel(1'b0);
      h.desel();
      `CHK(spi_mode3, 1'b0)
      $display("test select done");
      conclude();
   end
endmodule
